// File: hw/acmp_regs.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps

// Summary of operation
// - Registers decode as offsets above base address 0x4003C000.
// - Offset 0x00 reads masked interrupt status in bit 0.
// - Offset 0x04 bit 0 sets on interrupt condition regardless of mask.
// - Offset 0x08 bit 0 enables the comparator interrupt.
// - Reference control bit 9 powers the ladder; resets to zero.
// - Reference control bit 8 picks 32-unit (0) or 24-unit (1) ladder.
// - Reference control bits 3:0 select the ladder tap.
// - Offset 0x20 bit 1 shows the live comparator output level.
// - Control register at offset 0x24 is read/write, resets zero.
// - Control bits 10:9 select the positive input source.
// - Control bit 11 forwards or suppresses the converter trigger.
// - Control bits 6:5 and 7 choose the trigger condition.
// - Control bits 3:2 and 4 choose the interrupt condition.

// ********************************************************************
// Comparator register bank
// ********************************************************************
module acmp_regs
    import acmp_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Analog core
    input wire logic comparator_in,
    output logic ladder_power,
    output logic ladder_range,
    output logic [3:0] ladder_tap,
    output logic [1:0] positive_source_select,
    // Events
    output logic irq,
    output logic adc_trigger
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic irq_en;
        logic raw;
        logic ref_power;
        logic ladder_range;
        logic [3:0] ladder_tap;
        logic trigger_forward;
        logic [1:0] pos_src;
        logic trigger_level_value;
        logic [1:0] trigger_sense;
        logic irq_level_value;
        logic [1:0] irq_sense;
        logic output_level;
        logic irq;
        logic trig;
        logic [31:0] rdata;
    } acmp_state_t;

    acmp_state_t s_q;
    acmp_state_t s_d;
    logic irq_hit;
    logic trig_hit;
    logic sel;
    logic [5:0] ofs;

    // A register is selected only when the upper address bits match.
    function automatic logic hits(input logic [31:0] a, input logic [5:0] o);
        hits = (a[31:ACMP_DEC_LSB] == ACMP_BASE_ADDR[31:ACMP_DEC_LSB])
            && (a[5:0] == o);
    endfunction : hits

    assign sel = reg_addr[31:ACMP_DEC_LSB] == ACMP_BASE_ADDR[31:ACMP_DEC_LSB];
    assign ofs = reg_addr[5:0];

    // ****************************************************************
    // Condition detectors
    // ****************************************************************
    // The previous sample is the registered level, so edges need no
    // extra flop and the two detectors see the same history.
    acmp_sense u_irq_sense
    (
        .cur_level(comparator_in),
        .prev_level(s_q.output_level),
        .sense(s_q.irq_sense),
        .level_value(s_q.irq_level_value),
        .hit(irq_hit)
    );

    acmp_sense u_trig_sense
    (
        .cur_level(comparator_in),
        .prev_level(s_q.output_level),
        .sense(s_q.trigger_sense),
        .level_value(s_q.trigger_level_value),
        .hit(trig_hit)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.output_level = comparator_in;
        s_d.trig = trig_hit & s_q.trigger_forward;
        if (reg_wr && hits(reg_addr, OFS_RAW_IRQ_STATUS)
            && reg_wdata[COMPARATOR_IRQ_BIT])
        begin
            s_d.raw = 1'b0;
        end
        if (irq_hit)
        begin
            s_d.raw = 1'b1;
        end
        if (reg_wr && sel)
        begin
            unique case (ofs)
                OFS_IRQ_ENABLE:
                begin
                    s_d.irq_en = reg_wdata[COMPARATOR_IRQ_BIT];
                end
                OFS_REFERENCE_CONTROL:
                begin
                    s_d.ref_power = reg_wdata[REF_POWER_BIT];
                    s_d.ladder_range = reg_wdata[LADDER_RANGE_BIT];
                    s_d.ladder_tap =
                        reg_wdata[LADDER_TAP_MSB:LADDER_TAP_LSB];
                end
                OFS_COMPARATOR_CONTROL:
                begin
                    s_d.trigger_forward = reg_wdata[TRIGGER_FORWARD_BIT];
                    s_d.pos_src = reg_wdata[POS_SRC_MSB:POS_SRC_LSB];
                    s_d.trigger_level_value =
                        reg_wdata[TRIGGER_LEVEL_VALUE_BIT];
                    s_d.trigger_sense =
                        reg_wdata[TRIGGER_SENSE_MSB:TRIGGER_SENSE_LSB];
                    s_d.irq_level_value = reg_wdata[IRQ_LEVEL_VALUE_BIT];
                    s_d.irq_sense =
                        reg_wdata[IRQ_SENSE_MSB:IRQ_SENSE_LSB];
                end
                default:
                begin
                end
            endcase
        end
        s_d.irq = s_d.raw & s_d.irq_en;
        // Reserved bits read as zero, which also covers unmapped offsets.
        s_d.rdata = 32'h0000_0000;
        if (reg_rd && sel)
        begin
            unique case (ofs)
                OFS_MASKED_IRQ_STATUS:
                    s_d.rdata[COMPARATOR_IRQ_BIT] =
                        s_q.raw & s_q.irq_en;
                OFS_RAW_IRQ_STATUS:
                    s_d.rdata[COMPARATOR_IRQ_BIT] = s_q.raw;
                OFS_IRQ_ENABLE:
                    s_d.rdata[COMPARATOR_IRQ_BIT] = s_q.irq_en;
                OFS_REFERENCE_CONTROL:
                begin
                    s_d.rdata[REF_POWER_BIT] = s_q.ref_power;
                    s_d.rdata[LADDER_RANGE_BIT] = s_q.ladder_range;
                    s_d.rdata[LADDER_TAP_MSB:LADDER_TAP_LSB] = s_q.ladder_tap;
                end
                OFS_COMPARATOR_STATUS:
                    s_d.rdata[OUTPUT_LEVEL_BIT] = s_q.output_level;
                OFS_COMPARATOR_CONTROL:
                begin
                    s_d.rdata[TRIGGER_FORWARD_BIT] = s_q.trigger_forward;
                    s_d.rdata[POS_SRC_MSB:POS_SRC_LSB] = s_q.pos_src;
                    s_d.rdata[TRIGGER_LEVEL_VALUE_BIT] =
                        s_q.trigger_level_value;
                    s_d.rdata[TRIGGER_SENSE_MSB:TRIGGER_SENSE_LSB] =
                        s_q.trigger_sense;
                    s_d.rdata[IRQ_LEVEL_VALUE_BIT] = s_q.irq_level_value;
                    s_d.rdata[IRQ_SENSE_MSB:IRQ_SENSE_LSB] = s_q.irq_sense;
                end
                default:
                begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign ladder_power = s_q.ref_power;
    assign ladder_range = s_q.ladder_range;
    assign ladder_tap = s_q.ladder_tap;
    assign positive_source_select = s_q.pos_src;
    assign irq = s_q.irq;
    assign adc_trigger = s_q.trig;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence wr_to(logic [5:0] o);
        reg_wr && hits(reg_addr, o);
    endsequence

    sequence rd_of(logic [5:0] o);
        reg_rd && hits(reg_addr, o);
    endsequence

    a_unmapped_read_zero: assert property (
        reg_rd && !sel |=> reg_rdata == 32'h0000_0000)
        else $error("read outside the block returned data");

    a_masked_read: assert property (
        rd_of(OFS_MASKED_IRQ_STATUS) |=>
        reg_rdata == {31'h0, $past(s_q.raw & s_q.irq_en)})
        else $error("masked status read wrong");

    a_raw_sets: assert property (
        irq_hit |=> s_q.raw)
        else $error("raw status missed an interrupt condition");

    a_enable_write: assert property (
        wr_to(OFS_IRQ_ENABLE) |=>
        s_q.irq_en == $past(reg_wdata[COMPARATOR_IRQ_BIT]))
        else $error("enable bit not written");

    a_ladder_write: assert property (
        wr_to(OFS_REFERENCE_CONTROL) |=>
        {ladder_power, ladder_range, ladder_tap} ==
        $past({reg_wdata[9:8], reg_wdata[3:0]}))
        else $error("ladder outputs do not follow the write");

    a_ladder_stable: assert property (
        !(reg_wr && hits(reg_addr, OFS_REFERENCE_CONTROL)) |=>
        $stable(ladder_range) && $stable(ladder_tap))
        else $error("ladder control changed without a write");

    a_status_level: assert property (
        rd_of(OFS_COMPARATOR_STATUS) ##1 1'b1 |->
        reg_rdata[OUTPUT_LEVEL_BIT] == $past(comparator_in, 2)
        && reg_rdata[0] == 1'b0)
        else $error("status does not show the output level");

    a_source_write: assert property (
        wr_to(OFS_COMPARATOR_CONTROL) |=>
        positive_source_select == $past(reg_wdata[10:9]))
        else $error("source select not written");

    a_trigger_gate: assert property (
        !s_q.trigger_forward |=> !adc_trigger)
        else $error("trigger passed while suppressed");

    a_rise_trigger: assert property (
        s_q.trigger_forward && s_q.trigger_sense == SENSE_RISE
        && !s_q.output_level && comparator_in |=> adc_trigger)
        else $error("rising edge did not trigger");

    a_fall_irq: assert property (
        s_q.irq_sense == SENSE_FALL && s_q.output_level
        && !comparator_in |=> s_q.raw)
        else $error("falling edge did not raise raw status");

    a_raw_clear: assert property (
        reg_wr && hits(reg_addr, OFS_RAW_IRQ_STATUS)
        && reg_wdata[COMPARATOR_IRQ_BIT] && !irq_hit |=> !s_q.raw)
        else $error("raw status not cleared by a one");

    a_level_irq: assert property (
        s_q.irq_sense == SENSE_LEVEL
        && comparator_in == s_q.irq_level_value |=> s_q.raw)
        else $error("level condition did not raise raw status");

    a_irq_mask: assert property (
        irq == (s_q.raw && s_q.irq_en))
        else $error("interrupt is not raw and enable");

endmodule : acmp_regs

// File: hw/acmp_pkg.sv
package acmp_pkg;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [31:0] ACMP_BASE_ADDR = 32'h4003_C000;
    localparam int ACMP_DEC_LSB = 6;
    localparam logic [5:0] OFS_MASKED_IRQ_STATUS = 6'h00;
    localparam logic [5:0] OFS_RAW_IRQ_STATUS = 6'h04;
    localparam logic [5:0] OFS_IRQ_ENABLE = 6'h08;
    localparam logic [5:0] OFS_REFERENCE_CONTROL = 6'h10;
    localparam logic [5:0] OFS_COMPARATOR_STATUS = 6'h20;
    localparam logic [5:0] OFS_COMPARATOR_CONTROL = 6'h24;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int COMPARATOR_IRQ_BIT = 0;
    localparam int REF_POWER_BIT = 9;
    localparam int LADDER_RANGE_BIT = 8;
    localparam int LADDER_TAP_MSB = 3;
    localparam int LADDER_TAP_LSB = 0;
    localparam int OUTPUT_LEVEL_BIT = 1;
    localparam int TRIGGER_FORWARD_BIT = 11;
    localparam int POS_SRC_MSB = 10;
    localparam int POS_SRC_LSB = 9;
    localparam int TRIGGER_LEVEL_VALUE_BIT = 7;
    localparam int TRIGGER_SENSE_MSB = 6;
    localparam int TRIGGER_SENSE_LSB = 5;
    localparam int IRQ_LEVEL_VALUE_BIT = 4;
    localparam int IRQ_SENSE_MSB = 3;
    localparam int IRQ_SENSE_LSB = 2;

    // ****************************************************************
    // Reset values and encodings
    // ****************************************************************
    localparam logic [31:0] ACMP_REG_RESET = 32'h0000_0000;
    localparam logic [1:0] SENSE_LEVEL = 2'h0;
    localparam logic [1:0] SENSE_FALL = 2'h1;
    localparam logic [1:0] SENSE_RISE = 2'h2;
    localparam logic [1:0] SENSE_BOTH = 2'h3;

endpackage : acmp_pkg

// File: hw/acmp_sense.sv
`timescale 1ns/100ps

// ********************************************************************
// Output condition detector
// ********************************************************************
module acmp_sense
    import acmp_pkg::*;
(
    // Comparator samples
    input wire logic cur_level,
    input wire logic prev_level,
    // Condition select
    input wire logic [1:0] sense,
    input wire logic level_value,
    // Result
    output logic hit
);

    always_comb
    begin
        unique case (sense)
            SENSE_LEVEL: hit = (cur_level == level_value);
            SENSE_FALL: hit = prev_level & ~cur_level;
            SENSE_RISE: hit = ~prev_level & cur_level;
            SENSE_BOTH: hit = prev_level ^ cur_level;
        endcase
    end

endmodule : acmp_sense

// File: bench/acmp_regs_tb_top.sv
`timescale 1ns/100ps

// ********************************************************************
// Comparator register bank bench
// ********************************************************************
module acmp_regs_tb_top
    import acmp_pkg::*;
;
    logic mclk, rst;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic reg_wr, reg_rd, comparator_in;
    logic ladder_power, ladder_range, irq, adc_trigger;
    logic [3:0] ladder_tap;
    logic [1:0] positive_source_select;
    int miscompares = 0;
    int checked = 0;
    logic [5:0] ofs_list [5] = '{OFS_MASKED_IRQ_STATUS, OFS_RAW_IRQ_STATUS,
        OFS_IRQ_ENABLE, OFS_REFERENCE_CONTROL, OFS_COMPARATOR_CONTROL};

    acmp_regs i_dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .comparator_in(comparator_in), .ladder_power(ladder_power),
        .ladder_range(ladder_range), .ladder_tap(ladder_tap),
        .positive_source_select(positive_source_select), .irq(irq),
        .adc_trigger(adc_trigger)
    );

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic wo(input logic [5:0] o, input logic [31:0] d);
        wr(ACMP_BASE_ADDR | {26'h0, o}, d);
    endtask : wo
    // Read data stand in one cycle only, so sample mid-cycle after it.
    task automatic rchk(input logic [5:0] o, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= ACMP_BASE_ADDR | {26'h0, o};
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        check(reg_rdata, e);
    endtask : rchk
    function automatic logic ehit(input logic [1:0] s, input logic a,
        input logic b);
        return (s == SENSE_FALL) ? (a & ~b) : (s == SENSE_RISE) ? (~a & b) :
            (s == SENSE_BOTH) ? (a ^ b) : 1'b0;
    endfunction : ehit
    // The comparator is held high here, else level sense sets raw status.
    task automatic reset_chk();
        @(negedge mclk);
        check({22'h0, irq, adc_trigger, ladder_power,
            ladder_range, ladder_tap, positive_source_select}, 32'h0);
        for (int i = 0; i < 5; i++)
            rchk(ofs_list[i], 32'h0);
        rchk(OFS_COMPARATOR_STATUS, 32'h2);
    endtask : reset_chk

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    initial
    begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        wrap_up();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        logic [31:0] v, r;
        logic e;
        int n;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        comparator_in = 1'b1;
        r = $urandom(32'hFD94);
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        reset_chk();
        $display("test reset done");
        for (int i = 0; i < 12; i++)
        begin
            v = (i == 0) ? 32'h30C : ($urandom & 32'h30F);
            wo(OFS_REFERENCE_CONTROL, v);
            @(negedge mclk);
            check({26'h0, ladder_power, ladder_range,
                ladder_tap}, {26'h0, v[9:8], v[3:0]});
            rchk(OFS_REFERENCE_CONTROL, v);
        end
        wr(ACMP_BASE_ADDR + 32'h1010, ~v);
        wo(6'h0C, ~v);
        rchk(OFS_REFERENCE_CONTROL, v);
        rchk(6'h0C, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            v = (i == 0) ? 32'h40C : ($urandom & 32'hEFC);
            v[10] = v[10] & ~v[9];
            wo(OFS_COMPARATOR_CONTROL, v);
            @(negedge mclk);
            check({30'h0, positive_source_select}, {30'h0, v[10:9]});
            rchk(OFS_COMPARATOR_CONTROL, v);
        end
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            r = $urandom;
            wo(OFS_COMPARATOR_STATUS, 32'hFFFF_FFFF);
            comparator_in <= r[0];
            repeat (3) @(posedge mclk);
            rchk(OFS_COMPARATOR_STATUS, {30'h0, r[0], 1'b0});
        end
        $display("test status done");
        for (int i = 0; i < 64; i++)
        begin
            v = $urandom & 32'h8FC;
            r = $urandom;
            r[2] = (i < 16) ? ~r[1] : r[2];
            wo(OFS_COMPARATOR_CONTROL, v);
            wo(OFS_IRQ_ENABLE, {31'h0, r[0]});
            comparator_in <= r[1];
            repeat (4) @(posedge mclk);
            wo(OFS_RAW_IRQ_STATUS, 32'h1);
            comparator_in <= r[2];
            n = 0;
            repeat (4)
                @(negedge mclk) n += (adc_trigger !== 1'b0);
            if (v[6:5] != SENSE_LEVEL)
                check(n, {31'h0, v[11] & ehit(v[6:5], r[1], r[2])});
            check({31'h0, adc_trigger}, {31'h0, v[11] &
                (v[6:5] == SENSE_LEVEL) & (v[7] == r[2])});
            e = (v[3:2] == SENSE_LEVEL) ? (v[4] == r[1] || v[4] == r[2]) :
                ehit(v[3:2], r[1], r[2]);
            rchk(OFS_RAW_IRQ_STATUS, {31'h0, e});
            rchk(OFS_MASKED_IRQ_STATUS, {31'h0, e & r[0]});
            check({31'h0, irq}, {31'h0, e & r[0]});
        end
        $display("test events done");
        @(posedge mclk);
        rst <= 1'b1;
        comparator_in <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        reset_chk();
        $display("test second reset done");
        wrap_up();
    end
endmodule : acmp_regs_tb_top
